//--- design/ctg_clamp_timing.sv
`timescale 1ns/1ps
`include "ctg_consts.svh"

module ctg_clamp_timing
    import ctg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `CTG_DEV_ADDR
)
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    // Two-wire serial control port
    input  wire logic       i_scl,
    input  wire logic       i_sda_in,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // Video timing
    input  wire logic       i_hsync,
    input  wire logic       i_clamp_pin,
    // Converter data
    input  wire logic [7:0] i_adc_raw,
    output logic [7:0]      o_pixel,
    output logic [7:0]      o_clamp_offset,
    output logic            o_clamp
);

    ctg_top_t   r;
    ctg_top_t   n;
    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       trail;
    logic       ext_act;
    logic       win_int;
    logic       win;

    function automatic logic [7:0] read_reg(
        input logic [7:0] addr,
        input logic [7:0] ctrl,
        input logic [7:0] delay,
        input logic [7:0] len
    );
        case (addr)
            `CTG_REG_CTRL:  read_reg = ctrl;
            `CTG_REG_DELAY: read_reg = delay;
            `CTG_REG_LEN:   read_reg = len;
            default:        read_reg = `CTG_RD_UNMAPPED;
        endcase
    endfunction

    ctg_serial_port #(
        .DEV_ADDR (DEV_ADDR)
    ) u_port (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_scl     (i_scl),
        .i_sda_in  (i_sda_in),
        .o_sda_out (o_sda_out),
        .o_sda_oe  (o_sda_oe),
        .o_wr_stb  (wr_stb),
        .o_wr_addr (wr_addr),
        .o_wr_data (wr_data),
        .o_rd_addr (rd_addr),
        .i_rd_data (rd_data)
    );

    assign rd_data = read_reg(rd_addr, r.ctrl, r.delay, r.len);

    always_comb
    begin
        n         = r;
        n.hs_prev = i_hsync;
        trail     = r.hs_prev & ~i_hsync;
        if (wr_stb)
        begin
            case (wr_addr)
                `CTG_REG_CTRL:  n.ctrl  = wr_data;
                `CTG_REG_DELAY: n.delay = wr_data;
                `CTG_REG_LEN:   n.len   = wr_data;
                default:
                begin
                end
            endcase
        end
        // A new trailing edge restarts the window from scratch
        if (trail)
        begin
            if (r.delay != 8'h00)
            begin
                n.state = CTG_DELAY;
                n.cnt   = r.delay;
            end
            else if (r.len != 8'h00)
            begin
                n.state = CTG_CLAMP;
                n.cnt   = r.len;
            end
            else
                n.state = CTG_IDLE;
        end
        else
        begin
            unique case (r.state)
                CTG_IDLE:
                begin
                end
                CTG_DELAY:
                begin
                    if (r.cnt == 8'h01)
                    begin
                        // Zero duration means no window at all
                        n.state = (r.len != 8'h00) ? CTG_CLAMP : CTG_IDLE;
                        n.cnt   = r.len;
                    end
                    else
                        n.cnt = 8'(r.cnt - 8'h01);
                end
                CTG_CLAMP:
                begin
                    if (r.cnt == 8'h01)
                        n.state = CTG_IDLE;
                    else
                        n.cnt = 8'(r.cnt - 8'h01);
                end
            endcase
        end
        ext_act = i_clamp_pin ^ r.ctrl[`CTG_POL_LSB];
        win_int = (r.state == CTG_CLAMP);
        win     = r.ctrl[`CTG_SRC_BIT] ? ext_act : win_int;
        n.clamp = win;
        // Offset follows black only inside the window, then holds
        if (win)
        begin
            n.offset = i_adc_raw;
            n.pixel  = `CTG_BLACK;
        end
        else
            n.pixel = (i_adc_raw > r.offset) ? 8'(i_adc_raw - r.offset)
                                              : `CTG_BLACK;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            r       <= '0;
            r.state <= CTG_IDLE;
            r.ctrl  <= `CTG_CTRL_RST;
            r.delay <= `CTG_DELAY_RST;
            r.len   <= `CTG_LEN_RST;
        end
        else
            r <= n;
    end

    assign o_pixel        = r.pixel;
    assign o_clamp_offset = r.offset;
    assign o_clamp        = r.clamp;

    // Helper counters for the checks below
    logic [9:0] h_age;
    logic [7:0] h_delay;
    logic [8:0] h_run;
    logic [7:0] h_len;
    logic       h_enter;

    assign h_enter = (n.state == CTG_CLAMP) && (trail || !win_int);

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            h_age   <= 10'h000;
            h_delay <= 8'h00;
            h_run   <= 9'h000;
            h_len   <= 8'h00;
        end
        else
        begin
            if (trail)
            begin
                h_age   <= 10'h001;
                h_delay <= r.delay;
            end
            else if (h_age != 10'h3ff)
                h_age <= 10'(h_age + 10'h001);
            if (h_enter)
            begin
                h_run <= 9'h001;
                h_len <= n.cnt;
            end
            else if (n.state == CTG_CLAMP)
                h_run <= 9'(h_run + 9'h001);
            else
                h_run <= 9'h000;
        end
    end

    property p_src_ext;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        r.ctrl[`CTG_SRC_BIT] && !r.ctrl[`CTG_POL_LSB] && i_clamp_pin
            |=> o_clamp;
    endproperty
    a_src_ext: assert property (p_src_ext)
        else $error("pin clamp not followed");

    property p_pol_low;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        r.ctrl[`CTG_SRC_BIT] && r.ctrl[`CTG_POL_LSB] && !i_clamp_pin
            |=> o_clamp;
    endproperty
    a_pol_low: assert property (p_pol_low)
        else $error("inverted pin polarity not honoured");

    property p_start;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        $rose(win_int) |-> h_age == 10'({2'b00, h_delay} + 10'h001);
    endproperty
    a_start: assert property (p_start)
        else $error("window started at wrong pixel");

    property p_length;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        $fell(win_int) && !$past(trail)
            |-> $past(h_run) == {1'b0, $past(h_len)};
    endproperty
    a_length: assert property (p_length)
        else $error("window length wrong");

    property p_count_range;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        r.state == CTG_DELAY |-> r.cnt != 8'h00 && r.cnt <= h_delay;
    endproperty
    a_count_range: assert property (p_count_range)
        else $error("delay counter out of range");

    property p_black;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        $past(win) && !win && i_adc_raw == $past(i_adc_raw)
            |=> o_pixel == `CTG_BLACK;
    endproperty
    a_black: assert property (p_black)
        else $error("black level not zero after clamp");

    property p_wr_delay;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        wr_stb && wr_addr == `CTG_REG_DELAY |=> r.delay == $past(wr_data);
    endproperty
    a_wr_delay: assert property (p_wr_delay)
        else $error("serial write to delay lost");

    property p_src_int;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        !r.ctrl[`CTG_SRC_BIT] && !win_int |=> !o_clamp;
    endproperty
    a_src_int: assert property (p_src_int)
        else $error("pin leaked through with internal source");

endmodule

//--- design/ctg_consts.svh
`ifndef CTG_CONSTS_SVH
`define CTG_CONSTS_SVH

// Register offsets on the serial control port
`define CTG_REG_CTRL     8'h18
`define CTG_REG_DELAY    8'h19
`define CTG_REG_LEN      8'h1a

// Control register fields
`define CTG_SRC_BIT      4
`define CTG_POL_LSB      6
`define CTG_POL_MSB      7

// Reset values
`define CTG_CTRL_RST     8'h00
`define CTG_DELAY_RST    8'h04
`define CTG_LEN_RST      8'h28

// Black code and read value of unmapped offsets
`define CTG_BLACK        8'h00
`define CTG_RD_UNMAPPED  8'h00

// Serial port: device address is arbitrary
`define CTG_DEV_ADDR     7'h2a
`define CTG_BYTE_BITS    4'h8
`define CTG_MACK_BIT     4'h9

`endif

//--- design/ctg_pkg.sv
package ctg_pkg;

    typedef enum logic [2:0] {
        CTG_IDLE  = 3'b001,
        CTG_DELAY = 3'b010,
        CTG_CLAMP = 3'b100
    } ctg_win_state_t;

    typedef enum logic [4:0] {
        CTG_S_IDLE = 5'b00001,
        CTG_S_RECV = 5'b00010,
        CTG_S_ACK  = 5'b00100,
        CTG_S_SEND = 5'b01000,
        CTG_S_MACK = 5'b10000
    } ctg_ser_state_t;

    typedef enum logic [2:0] {
        CTG_K_DEV  = 3'b001,
        CTG_K_PTR  = 3'b010,
        CTG_K_DATA = 3'b100
    } ctg_rx_kind_t;

    typedef struct packed {
        ctg_ser_state_t state;
        ctg_rx_kind_t   kind;
        logic           scl_prev;
        logic           sda_prev;
        logic [3:0]     cnt;
        logic [7:0]     sh;
        logic           rw;
        logic [7:0]     ptr;
        logic           sda_oe;
        logic           wr_stb;
        logic [7:0]     wr_addr;
        logic [7:0]     wr_data;
    } ctg_ser_t;

    typedef struct packed {
        ctg_win_state_t state;
        logic [7:0]     cnt;
        logic           hs_prev;
        logic [7:0]     ctrl;
        logic [7:0]     delay;
        logic [7:0]     len;
        logic [7:0]     offset;
        logic           clamp;
        logic [7:0]     pixel;
    } ctg_top_t;

endpackage

//--- design/ctg_serial_port.sv
`timescale 1ns/1ps
`include "ctg_consts.svh"

module ctg_serial_port
    import ctg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `CTG_DEV_ADDR
)
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    // Two-wire pins
    input  wire logic       i_scl,
    input  wire logic       i_sda_in,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // Register access
    output logic            o_wr_stb,
    output logic [7:0]      o_wr_addr,
    output logic [7:0]      o_wr_data,
    output logic [7:0]      o_rd_addr,
    input  wire logic [7:0] i_rd_data
);

    ctg_ser_t r;
    ctg_ser_t n;
    logic     scl_rise;
    logic     scl_fall;
    logic     start;
    logic     stop;

    always_comb
    begin
        n          = r;
        n.scl_prev = i_scl;
        n.sda_prev = i_sda_in;
        n.wr_stb   = 1'b0;
        scl_rise   = ~r.scl_prev & i_scl;
        scl_fall   = r.scl_prev & ~i_scl;
        start      = r.scl_prev & i_scl & r.sda_prev & ~i_sda_in;
        stop       = r.scl_prev & i_scl & ~r.sda_prev & i_sda_in;
        if (start)
        begin
            n.state  = CTG_S_RECV;
            n.kind   = CTG_K_DEV;
            n.cnt    = 4'h0;
            n.sda_oe = 1'b0;
        end
        else if (stop)
        begin
            n.state  = CTG_S_IDLE;
            n.sda_oe = 1'b0;
        end
        else
        begin
            unique case (r.state)
                CTG_S_IDLE:
                begin
                end
                CTG_S_RECV:
                begin
                    if (scl_rise)
                    begin
                        n.sh  = {r.sh[6:0], i_sda_in};
                        n.cnt = 4'(r.cnt + 4'h1);
                    end
                    else if (scl_fall && r.cnt == `CTG_BYTE_BITS)
                    begin
                        n.cnt = 4'h0;
                        if (r.kind == CTG_K_DEV)
                        begin
                            // Other addresses stay silent until next start
                            if (r.sh[7:1] == DEV_ADDR)
                            begin
                                n.rw     = r.sh[0];
                                n.state  = CTG_S_ACK;
                                n.sda_oe = 1'b1;
                            end
                            else
                                n.state = CTG_S_IDLE;
                        end
                        else
                        begin
                            n.state  = CTG_S_ACK;
                            n.sda_oe = 1'b1;
                            if (r.kind == CTG_K_PTR)
                                n.ptr = r.sh;
                            else
                            begin
                                n.wr_stb  = 1'b1;
                                n.wr_addr = r.ptr;
                                n.wr_data = r.sh;
                                n.ptr     = 8'(r.ptr + 8'h01);
                            end
                        end
                    end
                end
                CTG_S_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (r.kind == CTG_K_DEV && r.rw)
                        begin
                            n.state  = CTG_S_SEND;
                            n.sh     = i_rd_data;
                            n.sda_oe = ~i_rd_data[7];
                            n.ptr    = 8'(r.ptr + 8'h01);
                            n.cnt    = 4'h0;
                        end
                        else
                        begin
                            n.state  = CTG_S_RECV;
                            n.sda_oe = 1'b0;
                            n.kind   = (r.kind == CTG_K_DEV) ? CTG_K_PTR
                                                             : CTG_K_DATA;
                        end
                    end
                end
                CTG_S_SEND:
                begin
                    if (scl_rise)
                        n.cnt = 4'(r.cnt + 4'h1);
                    else if (scl_fall)
                    begin
                        if (r.cnt == `CTG_BYTE_BITS)
                        begin
                            n.sda_oe = 1'b0;
                            n.state  = CTG_S_MACK;
                        end
                        else
                        begin
                            n.sh     = {r.sh[6:0], 1'b0};
                            n.sda_oe = ~r.sh[6];
                        end
                    end
                end
                CTG_S_MACK:
                begin
                    // A not-acknowledge from the master ends the read
                    if (scl_rise)
                    begin
                        if (i_sda_in)
                            n.state = CTG_S_IDLE;
                        else
                            n.cnt = `CTG_MACK_BIT;
                    end
                    else if (scl_fall && r.cnt == `CTG_MACK_BIT)
                    begin
                        n.state  = CTG_S_SEND;
                        n.sh     = i_rd_data;
                        n.sda_oe = ~i_rd_data[7];
                        n.ptr    = 8'(r.ptr + 8'h01);
                        n.cnt    = 4'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            r          <= '0;
            r.state    <= CTG_S_IDLE;
            r.kind     <= CTG_K_DEV;
            r.scl_prev <= 1'b1;
            r.sda_prev <= 1'b1;
        end
        else
            r <= n;
    end

    // Open drain: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe  = r.sda_oe;
    assign o_wr_stb  = r.wr_stb;
    assign o_wr_addr = r.wr_addr;
    assign o_wr_data = r.wr_data;
    assign o_rd_addr = r.ptr;

endmodule

//--- tb/ctg_clamp_timing_tb_top.sv
`timescale 1ns/1ps
`include "ctg_consts.svh"

module ctg_clamp_timing_tb_top;
    logic       clk;
    logic       resetn;
    logic       scl;
    logic       sda_m;
    logic       sda;
    logic       sda_out;
    logic       sda_oe;
    logic       line_go;
    logic       pin_low;
    logic       hsync;
    logic       pin;
    logic [7:0] raw;
    logic [7:0] pixel;
    logic [7:0] offset;
    logic       clamp;
    int         error_cnt = 0;
    int         samples_checked = 0;
    int         first;
    int         cnt;
    int         nz;

    // Open drain: pull-up unless someone pulls low
    assign sda = sda_m & ~(sda_oe & ~sda_out);

    ctg_clamp_timing ctg_clamp_timing_inst (
        .i_sys_clk      (clk),
        .i_resetn       (resetn),
        .i_scl          (scl),
        .i_sda_in       (sda),
        .o_sda_out      (sda_out),
        .o_sda_oe       (sda_oe),
        .i_hsync        (hsync),
        .i_clamp_pin    (pin),
        .i_adc_raw      (raw),
        .o_pixel        (pixel),
        .o_clamp_offset (offset),
        .o_clamp        (clamp)
    );

    ctg_video_src ctg_video_src_inst (
        .i_sys_clk   (clk),
        .i_line_go   (line_go),
        .i_pin_low   (pin_low),
        .o_hsync     (hsync),
        .o_clamp_pin (pin),
        .o_adc_raw   (raw)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic sbit(input logic b);
        sda_m = b;
        tick(3);
        scl = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(1);
    endtask

    task automatic rbit(output logic b);
        sda_m = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(2);
        b = sda;
        tick(2);
        scl = 1'b0;
        tick(1);
    endtask

    task automatic start();
        sda_m = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(1);
    endtask

    task automatic stop();
        sda_m = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b1;
        tick(4);
    endtask

    task automatic sbyte(input logic [7:0] v, input logic exp_ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            sbit(v[i]);
        rbit(a);
        check("ack", a, exp_ack);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        sbyte({`CTG_DEV_ADDR, 1'b0}, 1'b0);
        sbyte(a, 1'b0);
        sbyte(d, 1'b0);
        stop();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        start();
        sbyte({`CTG_DEV_ADDR, 1'b0}, 1'b0);
        sbyte(a, 1'b0);
        start();
        sbyte({`CTG_DEV_ADDR, 1'b1}, 1'b0);
        for (int i = 7; i >= 0; i--)
            rbit(v[i]);
        sbit(1'b1);
        stop();
    endtask

    // Edge index k counts clocks after the one that sees sync end
    task automatic run_line();
        logic prev;
        int   k;
        first = -1;
        cnt = 0;
        nz = 0;
        prev = 1'b0;
        line_go = 1'b1;
        tick(1);
        line_go = 1'b0;
        for (k = 0; k < 40; k++)
        begin
            @(posedge clk);
            #1;
            if (prev === 1'b1 && hsync === 1'b0)
                break;
            prev = hsync;
        end
        if (k == 40)
        begin
            check("sync edge", 0, 1);
            give_verdict();
        end
        for (k = 1; k <= 560; k++)
        begin
            @(posedge clk);
            #1;
            if (clamp === 1'b1)
            begin
                if (first < 0)
                    first = k;
                cnt++;
                if (pixel !== 8'h00)
                    nz++;
            end
        end
        tick(1);
    endtask

    task automatic t_regs();
        logic [7:0] v;
        rd(`CTG_REG_CTRL, v);
        check("ctrl reset", v, 8'h00);
        rd(`CTG_REG_DELAY, v);
        check("delay reset", v, 8'h04);
        rd(`CTG_REG_LEN, v);
        check("len reset", v, 8'h28);
        wr(8'h20, 8'h5a);
        rd(8'h20, v);
        check("unmapped", v, 8'h00);
        wr(`CTG_REG_CTRL, 8'hc0);
        rd(`CTG_REG_CTRL, v);
        check("ctrl", v, 8'hc0);
        wr(`CTG_REG_DELAY, 8'ha5);
        rd(`CTG_REG_DELAY, v);
        check("delay", v, 8'ha5);
        // Another address must not be answered
        start();
        sbyte({`CTG_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
        stop();
        $display("test regs done");
    endtask

    task automatic t_internal();
        wr(`CTG_REG_CTRL, 8'h00);
        wr(`CTG_REG_DELAY, 8'h04);
        wr(`CTG_REG_LEN, 8'h28);
        pin_low = 1'b0;
        run_line();
        // Window launched on the edge one past the programmed delay
        check("start", first, 5);
        check("length", cnt, 40);
        check("pixel in window", nz, 0);
        check("offset", offset, 8'h30);
        check("pixel", pixel, 8'h50 - 8'h30);
        $display("test internal done");
    endtask

    task automatic t_external();
        wr(`CTG_REG_CTRL, 8'h10);
        run_line();
        check("ext start", first, 12);
        check("ext length", cnt, 20);
        pin_low = 1'b1;
        run_line();
        check("ext inverted", cnt, 540);
        wr(`CTG_REG_CTRL, 8'h50);
        run_line();
        check("low start", first, 12);
        check("low length", cnt, 20);
        pin_low = 1'b0;
        $display("test external done");
    endtask

    task automatic t_bounds();
        logic [7:0] dt[3] = '{8'h00, 8'hff, 8'h07};
        logic [7:0] lt[3] = '{8'h01, 8'hff, 8'h00};
        wr(`CTG_REG_CTRL, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            wr(`CTG_REG_DELAY, dt[i]);
            wr(`CTG_REG_LEN, lt[i]);
            run_line();
            // Zero length must stay shut though the pin pulses
            check("bound length", cnt, lt[i]);
            if (lt[i] != 8'h00)
                check("bound start", first, dt[i] + 1);
        end
        $display("test bounds done");
    endtask

    initial
    begin
        resetn = 1'b0;
        scl = 1'b1;
        sda_m = 1'b1;
        line_go = 1'b0;
        pin_low = 1'b0;
        repeat (16) @(posedge clk);
        tick(1);
        resetn = 1'b1;
        tick(4);
        t_regs();
        t_internal();
        t_external();
        t_bounds();
        give_verdict();
    end
endmodule

//--- tb/ctg_video_src.sv
`timescale 1ns/1ps

module ctg_video_src
#(
    parameter int         HS_W    = 8,
    parameter int         BP_W    = 80,
    parameter int         PIN_DLY = 12,
    parameter int         PIN_LEN = 20,
    parameter logic [7:0] BLACK   = 8'h30,
    parameter logic [7:0] VIDEO   = 8'h50
)
(
    // Clock and line control
    input  wire logic       i_sys_clk,
    input  wire logic       i_line_go,
    input  wire logic       i_pin_low,
    // Source pins
    output logic            o_hsync,
    output logic            o_clamp_pin,
    output logic [7:0]      o_adc_raw
);
    logic [15:0] pos = 16'hffff;
    int          p;
    logic        pulse;

    initial
    begin
        o_hsync     = 1'b0;
        o_clamp_pin = 1'b0;
        o_adc_raw   = VIDEO;
    end

    always @(posedge i_sys_clk)
    begin
        if (i_line_go)
            pos <= 16'h0000;
        else if (pos != 16'hffff)
            pos <= pos + 16'h0001;
    end

    assign p     = int'(pos);
    // Pulse kept inside the back porch, never during sync
    assign pulse = p >= HS_W + PIN_DLY && p < HS_W + PIN_DLY + PIN_LEN;

    // Pins move on the falling edge, away from the sampling edge
    always @(negedge i_sys_clk)
    begin
        o_hsync     <= p < HS_W;
        o_clamp_pin <= pulse ^ i_pin_low;
        o_adc_raw   <= (p >= HS_W && p < HS_W + BP_W) ? BLACK : VIDEO;
    end
endmodule
